// ---- hw/pcsd_top.v ----
// Summary of operation
// R1: serial port 1 divider 8 bits; zero stops clock, N divides by N.
// R2: usb source field: 0 usb pll, 1 main clock, 2 and 3 reserved.
// R3: usb source changes only after update strobe written zero then one.
// R4: software keeps old and new source running before any update.
// R5: usb divider 8 bits resets to one; zero stops, N divides by N.
// R6: software programs usb source and divider for 48 MHz.
// R7: before usb moves to main clock, main runs 48 MHz from pll.
// R8: usb pll may stop only after usb moved to main clock.
// R9: output source 2 bits reset zero: irc, crystal, watchdog osc, main.
// R10: output selection applies only after bit 0 written zero then one.
// R11: output divider 8 bits resets zero; zero disables, N divides by N.
// R12: source switch and divider change produce no runt pulses.
`include "pcsd_defs.vh"

module pcsd_top (
  // system
  input  wire        clk,
  input  wire        rst,
  // axi4-lite write address
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // source clocks, sampled on clk
  input  wire        main_clk_in,
  input  wire        usb_pll_clk_in,
  input  wire        internal_rc_oscillator,
  input  wire        crystal_oscillator,
  input  wire        wdt_osc_clk_in,
  // generated clocks
  output reg         serial_port1_clock,
  output reg         usb_clk,
  output reg         clock_output_pin
);

  // divider step: {out, count}; one step per source half period
  function [8:0] div_step;
    input [8:0] st;
    input       edge_seen;
    input [7:0] n;
    reg   [7:0] cnt_inc;
    begin
      cnt_inc = st[7:0] + 8'h01;
      div_step = st;
      if (n == 8'h00) begin
        div_step = 9'h000;
      end else if (edge_seen) begin
        if (cnt_inc >= n) begin
          div_step = {~st[8], 8'h00};
        end else begin
          div_step = {st[8], cnt_inc};
        end
      end
    end
  endfunction

  // address decode hit
  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = (a == `PCSD_ADDR_SSP1_DIV) || (a == `PCSD_ADDR_USB_SEL) ||
                  (a == `PCSD_ADDR_USB_UPD)  || (a == `PCSD_ADDR_USB_DIV) ||
                  (a == `PCSD_ADDR_OUT_SEL)  || (a == `PCSD_ADDR_OUT_UPD) ||
                  (a == `PCSD_ADDR_OUT_DIV)  || (a == `PCSD_ADDR_STATUS);
    end
  endfunction

  // software registers
  reg  [7:0]  ssp1_div_reg;
  reg  [1:0]  usb_sel_reg;
  reg         usb_upd_reg;
  reg  [7:0]  usb_div_reg;
  reg  [1:0]  out_sel_reg;
  reg         out_upd_reg;
  reg  [7:0]  out_div_reg;
  // active selections and pending updates
  reg  [1:0]  usb_act_reg;
  reg  [1:0]  out_act_reg;
  reg         usb_pend_reg;
  reg         out_pend_reg;
  // sampled sources
  reg  [4:0]  src_q_reg;
  reg  [4:0]  src_p_reg;
  wire [4:0]  src_in;
  wire [4:0]  src_edge;
  // divider state and latched divide values
  reg  [7:0]  ssp1_cnt_reg;
  reg  [7:0]  usb_cnt_reg;
  reg  [7:0]  out_cnt_reg;
  reg  [7:0]  ssp1_n_reg;
  reg  [7:0]  usb_n_reg;
  reg  [7:0]  out_n_reg;
  // axi holding
  reg  [31:0] aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;
  wire        do_write;
  wire        wr_ok;
  wire        wr_lo;

  assign src_in   = {wdt_osc_clk_in, crystal_oscillator, internal_rc_oscillator,
                     usb_pll_clk_in, main_clk_in};
  assign src_edge = src_q_reg ^ src_p_reg;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_ok    = do_write && is_mapped(aw_addr_reg);
  assign wr_lo    = w_strb_reg[0];

  // source selection: usb and clock output
  reg  [2:0]  usb_idx;
  reg  [2:0]  usb_new_idx;
  reg  [2:0]  out_idx;
  reg  [2:0]  out_new_idx;
  always @* begin
    usb_idx     = (usb_act_reg == `PCSD_USB_SRC_MAIN) ? `PCSD_SRC_MAIN : `PCSD_SRC_USBPLL; // [R2]
    usb_new_idx = (usb_sel_reg == `PCSD_USB_SRC_MAIN) ? `PCSD_SRC_MAIN : `PCSD_SRC_USBPLL; // [R2]
    case (out_act_reg) // [R9]
      `PCSD_OUT_SRC_IRC:  out_idx = `PCSD_SRC_IRC;
      `PCSD_OUT_SRC_XTAL: out_idx = `PCSD_SRC_XTAL;
      `PCSD_OUT_SRC_WDT:  out_idx = `PCSD_SRC_WDT;
      default:            out_idx = `PCSD_SRC_MAIN;
    endcase
    case (out_sel_reg) // [R9]
      `PCSD_OUT_SRC_IRC:  out_new_idx = `PCSD_SRC_IRC;
      `PCSD_OUT_SRC_XTAL: out_new_idx = `PCSD_SRC_XTAL;
      `PCSD_OUT_SRC_WDT:  out_new_idx = `PCSD_SRC_WDT;
      default:            out_new_idx = `PCSD_SRC_MAIN;
    endcase
  end

  // switch only while output, old and new source are all low
  wire usb_swap = usb_pend_reg && !usb_clk && !src_q_reg[usb_idx] &&
                  !src_q_reg[usb_new_idx]; // [R12]
  wire out_swap = out_pend_reg && !clock_output_pin && !src_q_reg[out_idx] &&
                  !src_q_reg[out_new_idx]; // [R12]

  wire [8:0] ssp1_nx = div_step({serial_port1_clock, ssp1_cnt_reg},
                                src_edge[`PCSD_SRC_MAIN], ssp1_n_reg); // [R1]
  wire [8:0] usb_nx  = div_step({usb_clk, usb_cnt_reg},
                                src_edge[usb_idx], usb_n_reg); // [R5]
  wire [8:0] out_nx  = div_step({clock_output_pin, out_cnt_reg},
                                src_edge[out_idx], out_n_reg); // [R11]

  // clock generation
  always @(posedge clk) begin
    if (rst) begin
      src_q_reg          <= 5'h00;
      src_p_reg          <= 5'h00;
      serial_port1_clock <= 1'b0;
      usb_clk            <= 1'b0;
      clock_output_pin   <= 1'b0;
      ssp1_cnt_reg       <= 8'h00;
      usb_cnt_reg        <= 8'h00;
      out_cnt_reg        <= 8'h00;
      ssp1_n_reg         <= `PCSD_RST_SSP1_DIV;
      usb_n_reg          <= `PCSD_RST_USB_DIV;
      out_n_reg          <= `PCSD_RST_OUT_DIV;
    end else begin
      src_q_reg <= src_in;
      src_p_reg <= src_q_reg;
      {serial_port1_clock, ssp1_cnt_reg} <= ssp1_nx; // [R1]
      // new divide value taken only at a period boundary
      if (ssp1_nx == 9'h000) begin
        ssp1_n_reg <= ssp1_div_reg; // [R12]
      end
      if (usb_swap) begin
        {usb_clk, usb_cnt_reg} <= 9'h000;
        usb_n_reg              <= usb_div_reg;
      end else begin
        {usb_clk, usb_cnt_reg} <= usb_nx; // [R5]
        if (usb_nx == 9'h000) begin
          usb_n_reg <= usb_div_reg; // [R12]
        end
      end
      if (out_swap) begin
        {clock_output_pin, out_cnt_reg} <= 9'h000;
        out_n_reg                       <= out_div_reg;
      end else begin
        {clock_output_pin, out_cnt_reg} <= out_nx; // [R11]
        if (out_nx == 9'h000) begin
          out_n_reg <= out_div_reg; // [R12]
        end
      end
    end
  end

  // register writes and update strobes
  always @(posedge clk) begin
    if (rst) begin
      ssp1_div_reg <= `PCSD_RST_SSP1_DIV;
      usb_sel_reg  <= `PCSD_RST_USB_SEL;
      usb_upd_reg  <= 1'b0;
      usb_div_reg  <= `PCSD_RST_USB_DIV;
      out_sel_reg  <= `PCSD_RST_OUT_SEL;
      out_upd_reg  <= 1'b0;
      out_div_reg  <= `PCSD_RST_OUT_DIV;
      usb_act_reg  <= `PCSD_RST_USB_SEL;
      out_act_reg  <= `PCSD_RST_OUT_SEL;
      usb_pend_reg <= 1'b0;
      out_pend_reg <= 1'b0;
    end else begin
      if (usb_swap) begin
        usb_act_reg  <= usb_sel_reg;
        usb_pend_reg <= 1'b0;
      end
      if (out_swap) begin
        out_act_reg  <= out_sel_reg;
        out_pend_reg <= 1'b0;
      end
      if (wr_ok && wr_lo) begin
        case (aw_addr_reg)
          `PCSD_ADDR_SSP1_DIV: ssp1_div_reg <= w_data_reg[7:0]; // [R1]
          `PCSD_ADDR_USB_SEL:  usb_sel_reg  <= w_data_reg[1:0]; // [R3]
          `PCSD_ADDR_USB_DIV:  usb_div_reg  <= w_data_reg[7:0]; // [R5]
          `PCSD_ADDR_OUT_SEL:  out_sel_reg  <= w_data_reg[1:0]; // [R10]
          `PCSD_ADDR_OUT_DIV:  out_div_reg  <= w_data_reg[7:0]; // [R11]
          `PCSD_ADDR_USB_UPD: begin
            usb_upd_reg <= w_data_reg[0];
            // zero then one arms a switch; reserved codes are not applied
            if (!usb_upd_reg && w_data_reg[0] && !usb_sel_reg[1]) begin
              usb_pend_reg <= 1'b1; // [R3]
            end
          end
          `PCSD_ADDR_OUT_UPD: begin
            out_upd_reg <= w_data_reg[0];
            if (!out_upd_reg && w_data_reg[0]) begin
              out_pend_reg <= 1'b1; // [R10]
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // axi4-lite write channels
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PCSD_RESP_OKAY;
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      aw_addr_reg   <= 32'h00000000;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !aw_full_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_full_reg && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? `PCSD_RESP_OKAY : `PCSD_RESP_SLVERR;
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data mux
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `PCSD_ADDR_SSP1_DIV: rd_val[7:0] = ssp1_div_reg;
      `PCSD_ADDR_USB_SEL:  rd_val[1:0] = usb_sel_reg;
      `PCSD_ADDR_USB_UPD:  rd_val[0]   = usb_upd_reg;
      `PCSD_ADDR_USB_DIV:  rd_val[7:0] = usb_div_reg;
      `PCSD_ADDR_OUT_SEL:  rd_val[1:0] = out_sel_reg;
      `PCSD_ADDR_OUT_UPD:  rd_val[0]   = out_upd_reg;
      `PCSD_ADDR_OUT_DIV:  rd_val[7:0] = out_div_reg;
      `PCSD_ADDR_STATUS: begin
        rd_val[`PCSD_ST_USB_ACT_LSB+1:`PCSD_ST_USB_ACT_LSB] = usb_act_reg;
        rd_val[`PCSD_ST_OUT_ACT_LSB+1:`PCSD_ST_OUT_ACT_LSB] = out_act_reg;
        rd_val[`PCSD_ST_USB_PEND] = usb_pend_reg;
        rd_val[`PCSD_ST_OUT_PEND] = out_pend_reg;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // axi4-lite read channels
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCSD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? `PCSD_RESP_OKAY : `PCSD_RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pcsd_top

// ---- include/pcsd_defs.vh ----
`ifndef PCSD_DEFS_VH
`define PCSD_DEFS_VH

// register byte addresses
`define PCSD_ADDR_SSP1_DIV    32'h4004809C
`define PCSD_ADDR_USB_SEL     32'h400480C0
`define PCSD_ADDR_USB_UPD     32'h400480C4
`define PCSD_ADDR_USB_DIV     32'h400480C8
`define PCSD_ADDR_OUT_SEL     32'h400480E0
`define PCSD_ADDR_OUT_UPD     32'h400480E4
`define PCSD_ADDR_OUT_DIV     32'h400480E8
`define PCSD_ADDR_STATUS      32'h400480F0

// reset values
`define PCSD_RST_SSP1_DIV     8'h00
`define PCSD_RST_USB_SEL      2'h0
`define PCSD_RST_USB_DIV      8'h01
`define PCSD_RST_OUT_SEL      2'h0
`define PCSD_RST_OUT_DIV      8'h00

// usb source codes
`define PCSD_USB_SRC_PLL      2'h0
`define PCSD_USB_SRC_MAIN     2'h1

// clock output source codes
`define PCSD_OUT_SRC_IRC      2'h0
`define PCSD_OUT_SRC_XTAL     2'h1
`define PCSD_OUT_SRC_WDT      2'h2
`define PCSD_OUT_SRC_MAIN     2'h3

// source vector positions
`define PCSD_SRC_MAIN         3'h0
`define PCSD_SRC_USBPLL       3'h1
`define PCSD_SRC_IRC          3'h2
`define PCSD_SRC_XTAL         3'h3
`define PCSD_SRC_WDT          3'h4

// status register fields
`define PCSD_ST_USB_ACT_LSB   0
`define PCSD_ST_OUT_ACT_LSB   2
`define PCSD_ST_USB_PEND      4
`define PCSD_ST_OUT_PEND      5

// axi responses
`define PCSD_RESP_OKAY        2'h0
`define PCSD_RESP_SLVERR      2'h2

`endif

// ---- verification/pcsd_top_monitor.sv ----
`include "pcsd_defs.vh"

module pcsd_top_monitor (
  // system and bus
  input logic        clk, rst,
  input logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata,
  input logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic [3:0]  s_axi_wstrb,
  input logic [1:0]  s_axi_bresp, s_axi_rresp,
  input logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input logic        s_axi_rvalid, s_axi_rready,
  // clocks
  input logic        main_clk_in, usb_pll_clk_in, internal_rc_oscillator,
  input logic        crystal_oscillator, wdt_osc_clk_in,
  input logic        serial_port1_clock, usb_clk, clock_output_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wrote_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // any write seen since reset
  always @(posedge clk) begin
    if (rst) wrote_reg <= 1'h0;
    else if (s_axi_awvalid && s_axi_awready) wrote_reg <= 1'h1;
  end

  a_reset_quiet: assert property (disable iff (1'h0) $past(rst) |-> !s_axi_bvalid &&
    !s_axi_rvalid && !usb_clk && !serial_port1_clock && !clock_output_pin)
    else $error("outputs active after reset");
  a_idle_clocks: assert property (!wrote_reg |-> !serial_port1_clock && !clock_output_pin)
    else $error("divided clock runs with zero divider");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  a_error_data: assert property (s_axi_rvalid && s_axi_rresp == `PCSD_RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read returns data");
  a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp == `PCSD_RESP_OKAY ||
    s_axi_bresp == `PCSD_RESP_SLVERR) else $error("bad write response code");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_error: cover property (s_axi_rvalid && s_axi_rresp == `PCSD_RESP_SLVERR);
  c_usb: cover property ($rose(usb_clk));
endmodule // pcsd_top_monitor

bind pcsd_top pcsd_top_monitor mon (.*);

// ---- verification/pcsd_bench.sv ----
`include "pcsd_defs.vh"

module pcsd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, serial_port1_clock, usb_clk, clock_output_pin;
  logic        main_clk_in, usb_pll_clk_in, internal_rc_oscillator;
  logic        crystal_oscillator, wdt_osc_clk_in;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  integer      n_fail, n_tests, cyc, k;
  wire [2:0]   gen = {clock_output_pin, usb_clk, serial_port1_clock};

  pcsd_top dut (.*);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // source clocks of distinct half periods, and run limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    main_clk_in <= (cyc % 4) < 2;
    usb_pll_clk_in <= (cyc % 6) < 3;
    internal_rc_oscillator <= (cyc % 8) < 4;
    crystal_oscillator <= (cyc % 10) < 5;
    wdt_osc_clk_in <= (cyc % 12) < 6;
    if (cyc == 80000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // handshakes judged on the values sampled at each rising edge
  task wr(input [31:0] a, input [31:0] d, input [1:0] er);
    logic ta, tw, tb;
    begin
      ta = 0; tw = 0; tb = 0;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
      while (!tb) begin
        @(posedge clk);
        if (!ta && s_axi_awvalid && s_axi_awready) begin
          ta = 1;
          s_axi_awvalid <= 1'h0;
        end
        if (!tw && s_axi_wvalid && s_axi_wready) begin
          tw = 1;
          s_axi_wvalid <= 1'h0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          tb = 1;
          rsp = s_axi_bresp;
          s_axi_bready <= 1'h0;
        end
      end
      chk(rsp, er);
    end
  endtask

  task rd(input [31:0] a, input [31:0] e, input [1:0] er);
    logic ta, tr;
    begin
      ta = 0; tr = 0;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
      while (!tr) begin
        @(posedge clk);
        if (!ta && s_axi_arvalid && s_axi_arready) begin
          ta = 1;
          s_axi_arvalid <= 1'h0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
          tr = 1;
          rdat = s_axi_rdata;
          rsp = s_axi_rresp;
          s_axi_rready <= 1'h0;
        end
      end
      chk(rdat, e);
      chk(rsp, er);
    end
  endtask

  // update strobe: zero then one
  task upd(input [31:0] a);
    begin
      wr(a, 32'h0, 2'h0);
      wr(a, 32'h1, 2'h0);
    end
  endtask

  // period in clk cycles between third and fourth rise, 0 if stopped
  task meas(input integer s, input [31:0] e);
    integer c, r;
    logic p;
    begin
      c = 0; r = 0;
      @(negedge clk);
      p = gen[s];
      while (r < 4 && c < 5000) begin
        @(negedge clk);
        c = c + 1;
        if (gen[s] && !p) begin
          r = r + 1;
          if (r == 3) c = 0;
        end
        p = gen[s];
      end
      chk((r == 4) ? c : 0, e);
    end
  endtask

  initial begin
    n_fail = 0; n_tests = 0; cyc = 0; rst = 1'h1;
    s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0; s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0; s_axi_awaddr = 32'h0; s_axi_wdata = 32'h0; s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF; main_clk_in = 1'h0; usb_pll_clk_in = 1'h0;
    internal_rc_oscillator = 1'h0; crystal_oscillator = 1'h0; wdt_osc_clk_in = 1'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(`PCSD_ADDR_SSP1_DIV, 32'h0, 2'h0);
    rd(`PCSD_ADDR_USB_SEL, 32'h0, 2'h0);
    rd(`PCSD_ADDR_USB_UPD, 32'h0, 2'h0);
    rd(`PCSD_ADDR_USB_DIV, 32'h1, 2'h0);
    rd(`PCSD_ADDR_OUT_SEL, 32'h0, 2'h0);
    rd(`PCSD_ADDR_OUT_UPD, 32'h0, 2'h0);
    rd(`PCSD_ADDR_OUT_DIV, 32'h0, 2'h0);
    rd(32'h40048000, 32'h0, 2'h2);
    meas(0, 0);
    meas(2, 0);
    meas(1, 6);
    wr(`PCSD_ADDR_SSP1_DIV, 32'hFFFFFF05, 2'h0);
    rd(`PCSD_ADDR_SSP1_DIV, 32'h5, 2'h0);
    meas(0, 20);
    wr(`PCSD_ADDR_SSP1_DIV, 32'h1, 2'h0);
    meas(0, 4);
    wr(`PCSD_ADDR_SSP1_DIV, 32'hFF, 2'h0);
    meas(0, 1020);
    wr(`PCSD_ADDR_SSP1_DIV, 32'h0, 2'h0);
    meas(0, 0);
    wr(`PCSD_ADDR_USB_SEL, 32'h1, 2'h0);
    meas(1, 6);
    wr(`PCSD_ADDR_USB_UPD, 32'h0, 2'h0);
    meas(1, 6);
    wr(`PCSD_ADDR_USB_UPD, 32'h1, 2'h0);
    meas(1, 4);
    wr(`PCSD_ADDR_USB_DIV, 32'h3, 2'h0);
    meas(1, 12);
    wr(`PCSD_ADDR_USB_SEL, 32'h2, 2'h0);
    upd(`PCSD_ADDR_USB_UPD);
    meas(1, 12);
    rd(`PCSD_ADDR_USB_SEL, 32'h2, 2'h0);
    rd(`PCSD_ADDR_STATUS, 32'h1, 2'h0);
    wr(`PCSD_ADDR_USB_DIV, 32'h0, 2'h0);
    meas(1, 0);
    wr(`PCSD_ADDR_USB_SEL, 32'h0, 2'h0);
    upd(`PCSD_ADDR_USB_UPD);
    wr(`PCSD_ADDR_USB_DIV, 32'h1, 2'h0);
    meas(1, 6);
    wr(`PCSD_ADDR_OUT_DIV, 32'h1, 2'h0);
    for (k = 0; k < 4; k = k + 1) begin
      wr(`PCSD_ADDR_OUT_SEL, k, 2'h0);
      upd(`PCSD_ADDR_OUT_UPD);
      meas(2, (k == 3) ? 4 : 8 + 2 * k);
    end
    wr(`PCSD_ADDR_OUT_SEL, 32'h1, 2'h0);
    wr(`PCSD_ADDR_OUT_UPD, 32'h0, 2'h0);
    meas(2, 4);
    wr(`PCSD_ADDR_OUT_DIV, 32'h2, 2'h0);
    meas(2, 8);
    rd(`PCSD_ADDR_STATUS, 32'hC, 2'h0);
    wr(32'h40048000, 32'h1, 2'h2);
    give_verdict();
  end
endmodule // pcsd_bench
